/* File: hw/watchdog_guarded_pkg.sv */
// Summary of operation
// (R01) counter enable changes only when guard bit 7 is 0
// (R02) counter writes accepted only while counter enable set
// (R03) control enable changes only when guard bit 5 is 0
// (R04) run and flag writable only with control enable
// (R05) run bit changes only when guard bit 3 is 0
// (R06) counter increments while run set, else holds
// (R07) run set by reset or guarded write of one
// (R08) run cleared by guarded write of zero
// (R09) reset flag changes only when guard bit 1 is 0
// (R10) overflow sets reset flag and raises internal reset
// (R11) flag cleared by pin reset or guarded zero write
// (R12) software writes zero guard alongside enable bits
// (R13) each zero-guarded bit updates in one cycle
package watchdog_guarded_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [23:0] ADDR_CONTROL_STATUS = 24'hFFF03B;
  localparam logic [23:0] ADDR_COUNTER = 24'hFFF03C;
  localparam int BIT_COUNTER_GUARD = 7;
  localparam int BIT_COUNTER_WE = 6;
  localparam int BIT_CONTROL_GUARD = 5;
  localparam int BIT_CONTROL_WE = 4;
  localparam int BIT_RUN_GUARD = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_FLAG_GUARD = 1;
  localparam int BIT_FLAG = 0;
  localparam logic RST_COUNTER_WE = 1'b0;
  localparam logic RST_CONTROL_WE = 1'b0;
  localparam logic RST_RUN = 1'b1;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [7:0] RST_COUNTER = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;
endpackage

/* File: hw/watchdog_guarded_control.sv */
// Our own choice: strobed register access.
module watchdog_guarded_control
  import watchdog_guarded_pkg::*;
#(
  parameter int COUNTER_WIDTH = 8
)(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_external_reset_pin,
  input wire logic [23:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_internal_reset,
  output logic o_watchdog_run
);

  // ****************************************
  // local constants
  // ****************************************
  // counter constants sized to the configured counter width
  localparam logic [COUNTER_WIDTH-1:0] COUNT_RESET = COUNTER_WIDTH'(RST_COUNTER);
  localparam logic [COUNTER_WIDTH-1:0] COUNT_ONE = COUNTER_WIDTH'(1);

  // ****************************************
  // address and guard decode
  // ****************************************
  // true when the bus address names the given register
  function automatic logic addr_hit(
    input logic [23:0] addr,
    input logic [23:0] target
  );
  begin
    addr_hit = (addr == target);
  end
  endfunction

  // true when a write lets the bit below the given guard change
  function automatic logic guard_open(
    input logic [7:0] data,
    input int guard_pos
  );
  begin
    guard_open = !data[guard_pos];
  end
  endfunction

  // ****************************************
  // data shaping
  // ****************************************
  // status byte as software sees it; guard positions always read one
  function automatic logic [7:0] status_word(
    input logic counter_we,
    input logic control_we,
    input logic run,
    input logic flag
  );
  begin
    status_word = DATA_ZERO;
    status_word[BIT_COUNTER_GUARD] = 1'b1; // see (R01)
    status_word[BIT_COUNTER_WE] = counter_we;
    status_word[BIT_CONTROL_GUARD] = 1'b1; // see (R03)
    status_word[BIT_CONTROL_WE] = control_we;
    status_word[BIT_RUN_GUARD] = 1'b1; // see (R05)
    status_word[BIT_RUN] = run;
    status_word[BIT_FLAG_GUARD] = 1'b1; // see (R09)
    status_word[BIT_FLAG] = flag;
  end
  endfunction

  // counter byte as software sees it
  function automatic logic [7:0] counter_word(
    input logic [COUNTER_WIDTH-1:0] value
  );
  begin
    counter_word = 8'(value);
  end
  endfunction

  // next count; the wrap itself is handled by the internal reset
  function automatic logic [COUNTER_WIDTH-1:0] counter_step(
    input logic [COUNTER_WIDTH-1:0] value
  );
  begin
    counter_step = value + COUNT_ONE;
  end
  endfunction

  // true on the last count before the counter wraps
  function automatic logic counter_at_top(
    input logic [COUNTER_WIDTH-1:0] value
  );
  begin
    counter_at_top = &value;
  end
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic counter_write_enable_r;
  logic control_write_enable_r;
  logic watchdog_run_r;
  logic watchdog_reset_flag_r;
  logic [COUNTER_WIDTH-1:0] watchdog_counter_r;
  logic internal_reset_r;

  // ****************************************
  // bus decode
  // ****************************************
  logic wr_csr;
  logic wr_cnt;
  logic rd_csr;
  logic rd_cnt;

  // unmapped addresses select nothing: writes are dropped, reads give zero
  always_comb
  begin
    wr_csr = 1'b0;
    wr_cnt = 1'b0;
    rd_csr = 1'b0;
    rd_cnt = 1'b0;
    if (addr_hit(i_addr, ADDR_CONTROL_STATUS))
    begin
      wr_csr = i_wr;
      rd_csr = i_rd;
    end
    else if (addr_hit(i_addr, ADDR_COUNTER))
    begin
      wr_cnt = i_wr;
      rd_cnt = i_rd;
    end
  end

  // ****************************************
  // write qualifiers
  // ****************************************
  logic take_counter_we;
  logic take_control_we;
  logic take_run;
  logic take_flag;

  // a field moves only when its own guard is written as zero
  always_comb
  begin
    take_counter_we = 1'b0;
    take_control_we = 1'b0;
    take_run = 1'b0;
    take_flag = 1'b0;
    if (wr_csr)
    begin
      take_counter_we = guard_open(i_wdata, BIT_COUNTER_GUARD); // see (R01) see (R13)
      take_control_we = guard_open(i_wdata, BIT_CONTROL_GUARD); // see (R03) see (R13)
      if (control_write_enable_r) // see (R04)
      begin
        take_run = guard_open(i_wdata, BIT_RUN_GUARD); // see (R05)
        take_flag = guard_open(i_wdata, BIT_FLAG_GUARD); // see (R09)
      end
    end
  end

  // ****************************************
  // restart sources
  // ****************************************
  logic soft_restart;
  logic overflow;

  // pin reset and watchdog reset both return the enables, run bit and counter to their reset state
  assign soft_restart = i_external_reset_pin || internal_reset_r;
  assign overflow = watchdog_run_r && counter_at_top(watchdog_counter_r); // see (R10)

  // ****************************************
  // counter write enable
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      counter_write_enable_r <= RST_COUNTER_WE;
    end
    else if (soft_restart)
    begin
      counter_write_enable_r <= RST_COUNTER_WE;
    end
    else if (take_counter_we) // see (R01)
    begin
      counter_write_enable_r <= i_wdata[BIT_COUNTER_WE];
    end
    else
    begin
      counter_write_enable_r <= counter_write_enable_r;
    end
  end

  // ****************************************
  // control write enable
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      control_write_enable_r <= RST_CONTROL_WE;
    end
    else if (soft_restart)
    begin
      control_write_enable_r <= RST_CONTROL_WE;
    end
    else if (take_control_we) // see (R03)
    begin
      control_write_enable_r <= i_wdata[BIT_CONTROL_WE];
    end
    else
    begin
      control_write_enable_r <= control_write_enable_r;
    end
  end

  // ****************************************
  // run bit
  // ****************************************
  // run bit set on any reset
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      watchdog_run_r <= RST_RUN; // see (R07)
    end
    else if (soft_restart)
    begin
      watchdog_run_r <= RST_RUN; // see (R07)
    end
    else if (take_run) // see (R04) see (R05)
    begin
      watchdog_run_r <= i_wdata[BIT_RUN]; // see (R07) see (R08)
    end
    else
    begin
      watchdog_run_r <= watchdog_run_r;
    end
  end

  // ****************************************
  // reset-cause flag
  // ****************************************
  // flag survives internal reset; overflow wins over a clearing write
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      watchdog_reset_flag_r <= RST_FLAG; // see (R11)
    end
    else if (i_external_reset_pin)
    begin
      watchdog_reset_flag_r <= RST_FLAG; // see (R11)
    end
    else if (overflow)
    begin
      watchdog_reset_flag_r <= 1'b1; // see (R10)
    end
    else if (take_flag) // see (R04) see (R09)
    begin
      watchdog_reset_flag_r <= i_wdata[BIT_FLAG]; // see (R11)
    end
    else
    begin
      watchdog_reset_flag_r <= watchdog_reset_flag_r;
    end
  end

  // ****************************************
  // watchdog counter
  // ****************************************
  // a software load wins over counting in the same cycle
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      watchdog_counter_r <= COUNT_RESET;
    end
    else if (soft_restart)
    begin
      watchdog_counter_r <= COUNT_RESET;
    end
    else if (wr_cnt && counter_write_enable_r) // see (R02)
    begin
      watchdog_counter_r <= COUNTER_WIDTH'(i_wdata);
    end
    else if (watchdog_run_r) // see (R06)
    begin
      watchdog_counter_r <= counter_step(watchdog_counter_r);
    end
    else
    begin
      watchdog_counter_r <= watchdog_counter_r;
    end
  end

  // ****************************************
  // internal reset
  // ****************************************
  // the pin takes priority, so no pulse follows an overflow it overrides
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      internal_reset_r <= 1'b0;
    end
    else if (i_external_reset_pin)
    begin
      internal_reset_r <= 1'b0;
    end
    else
    begin
      internal_reset_r <= overflow; // see (R10)
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= DATA_ZERO;
    end
    else if (rd_csr)
    begin
      o_rdata <= status_word(counter_write_enable_r, control_write_enable_r,
        watchdog_run_r, watchdog_reset_flag_r);
    end
    else if (rd_cnt)
    begin
      o_rdata <= counter_word(watchdog_counter_r);
    end
    else
    begin
      o_rdata <= DATA_ZERO;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_internal_reset = internal_reset_r;
  assign o_watchdog_run = watchdog_run_r;

endmodule

/* File: verif/watchdog_guarded_control_assertions.sv */
module watchdog_guarded_control_assertions
  import watchdog_guarded_pkg::*;
#(parameter int COUNTER_WIDTH = 8)
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_external_reset_pin,
  input wire logic [23:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_internal_reset,
  input wire logic o_watchdog_run
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire cs_rd = i_rd && i_addr == ADDR_CONTROL_STATUS;
  wire calm = !i_external_reset_pin && !o_internal_reset;
  chk_guard_ones: assert property (cs_rd |=> (o_rdata & 8'hAA) == 8'hAA)
    else $error("guard bit read as zero");
  chk_idle_zero: assert property (!i_rd |=> o_rdata == DATA_ZERO)
    else $error("read data without read");
  chk_run_read: assert property (cs_rd |=> o_rdata[BIT_RUN] == $past(o_watchdog_run))
    else $error("run bit read wrong");
  chk_run_guard: assert property (i_wr && i_addr == ADDR_CONTROL_STATUS &&
    i_wdata[BIT_RUN_GUARD] && calm |=> $stable(o_watchdog_run)) else $error("guarded run moved");
  chk_pulse_one: assert property (o_internal_reset |=> !o_internal_reset)
    else $error("internal reset too long");
  chk_irst_run: assert property (o_internal_reset |=> o_watchdog_run)
    else $error("run not set by reset");
  chk_pin_run: assert property (i_external_reset_pin |=> o_watchdog_run && !o_internal_reset)
    else $error("pin reset wrong");
  chk_stop_quiet: assert property (!o_watchdog_run |=> !o_internal_reset)
    else $error("overflow while stopped");
endmodule
bind watchdog_guarded_control watchdog_guarded_control_assertions
  #(.COUNTER_WIDTH(COUNTER_WIDTH)) u_chk (.*);

/* File: verif/tb_top.sv */
module tb_top
  import watchdog_guarded_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 0, i_rst = 1, i_external_reset_pin = 0, i_wr = 0, i_rd = 0;
  logic [23:0] i_addr = '0;
  logic [7:0] i_wdata = '0;
  wire [7:0] o_rdata;
  wire o_internal_reset, o_watchdog_run;
  int error_cnt = 0, n_tests = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  watchdog_guarded_control #(.COUNTER_WIDTH(4)) i_dut (.*);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'h0;
    @(negedge i_clk_sys);
    chk(o_rdata, e);
  endtask
  task automatic complete_run;
    $display("errors=%0d tests=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    rd(ADDR_CONTROL_STATUS, 8'hAE);
    wr(ADDR_CONTROL_STATUS, 8'h9A);
    wr(ADDR_CONTROL_STATUS, 8'hA2);
    rd(ADDR_CONTROL_STATUS, 8'hBA);
    chk({7'h00, o_watchdog_run}, 8'h00);
    rd(24'hFFF03A, 8'h00);
    wr(ADDR_CONTROL_STATUS, 8'h6A);
    wr(ADDR_COUNTER, 8'h03);
    rd(ADDR_COUNTER, 8'h03);
    rd(ADDR_COUNTER, 8'h03);
    wr(ADDR_CONTROL_STATUS, 8'h2A);
    wr(ADDR_COUNTER, 8'h09);
    rd(ADDR_COUNTER, 8'h03);
    wr(ADDR_CONTROL_STATUS, 8'hA6);
    for (int k = 0; k < 40 && o_internal_reset !== 1'h1; k++)
      @(negedge i_clk_sys);
    chk({7'h00, o_internal_reset}, 8'h01);
    rd(ADDR_CONTROL_STATUS, 8'hAF);
    wr(ADDR_CONTROL_STATUS, 8'hAC);
    rd(ADDR_CONTROL_STATUS, 8'hAF);
    wr(ADDR_CONTROL_STATUS, 8'h9A);
    wr(ADDR_CONTROL_STATUS, 8'hAC);
    rd(ADDR_CONTROL_STATUS, 8'hBE);
    @(posedge i_clk_sys) i_external_reset_pin <= 1'h1;
    @(posedge i_clk_sys) i_external_reset_pin <= 1'h0;
    rd(ADDR_CONTROL_STATUS, 8'hAE);
    chk({7'h00, o_watchdog_run}, 8'h01);
    complete_run;
  end
  initial
  begin
    repeat (500) @(posedge i_clk_sys);
    error_cnt++;
    complete_run;
  end
endmodule
